// [rtl/pmt_pkg.sv]
`default_nettype none
package pmt_pkg;
  // ****************
  // register indices, byte address is index * 4
  // ****************
  localparam logic [7:0] PMT_IDX_FAST_COND = 8'h92;
  localparam logic [7:0] PMT_IDX_GEN_COND  = 8'h94;
  localparam logic [7:0] PMT_IDX_SLOW_COND = 8'h96;
  localparam logic [7:0] PMT_IDX_FAST_IRQM = 8'h98;
  localparam logic [7:0] PMT_IDX_GEN_IRQM  = 8'h9A;
  localparam logic [7:0] PMT_IDX_SLOW_IRQM = 8'h9C;
  localparam logic [7:0] PMT_IDX_SOFT      = 8'h9E;
  localparam logic [7:0] PMT_IDX_CTRL      = 8'hB0;
  localparam logic [7:0] PMT_IDX_FAST_PER  = 8'hB4;
  localparam logic [7:0] PMT_IDX_GEN_PER   = 8'hB8;
  localparam logic [7:0] PMT_IDX_IST       = 8'hBC;
  localparam logic [7:0] PMT_IDX_ICLR      = 8'hBD;
  localparam logic [7:0] PMT_IDX_IEN       = 8'hBE;
  localparam logic [7:0] PMT_IDX_SMIST     = 8'hBF;
  // ****************
  // fields and reset values
  // ****************
  localparam logic [15:0] PMT_COND_MASK = 16'h03FF;
  localparam logic [15:0] PMT_SLOW_MASK = 16'hC3FF;
  localparam int PMT_BASE_LSB = 14;
  localparam int PMT_B_VIDEO = 9;
  localparam int PMT_B_IRQ   = 8;
  localparam int PMT_B_DMA   = 7;
  localparam int PMT_B_KBD   = 6;
  localparam int PMT_B_DISK  = 5;
  localparam int PMT_B_PAR   = 4;
  localparam int PMT_B_SER   = 3;
  localparam int PMT_B_TRAP1 = 2;
  localparam int PMT_B_TRAP0 = 1;
  localparam int PMT_B_PCI   = 0;
  localparam int PMT_SOFT_SMI = 0;
  localparam int PMT_SOFT_BLK = 1;
  localparam int PMT_ST_SOFT  = 3;
  localparam logic [31:0] PMT_RST_VAL = 32'h0000_0000;
  // ****************
  // timing at 200 MHz
  // ****************
  localparam longint PMT_CLK_MHZ = 200;
  localparam longint PMT_SLOW_US0 = 70;
  localparam longint PMT_SLOW_US1 = 1200000;
  localparam longint PMT_SLOW_US2 = 4800000;
  localparam longint PMT_SLOW_US3 = 9700000;
  localparam longint PMT_SLOW_CYC0 = PMT_SLOW_US0 * PMT_CLK_MHZ;
  localparam longint PMT_SLOW_CYC1 = PMT_SLOW_US1 * PMT_CLK_MHZ;
  localparam longint PMT_SLOW_CYC2 = PMT_SLOW_US2 * PMT_CLK_MHZ;
  localparam longint PMT_SLOW_CYC3 = PMT_SLOW_US3 * PMT_CLK_MHZ;
  localparam longint PMT_BLK_US = 1;
  localparam logic [31:0] PMT_BLK_CYC = 32'(PMT_BLK_US * PMT_CLK_MHZ);
  localparam logic [7:0] PMT_PULSE_CYC = 8'h04;

  typedef enum logic [1:0] {
    PMT_SMI_IDLE   = 2'b00,
    PMT_SMI_DRIVE  = 2'b01,
    PMT_SMI_MASKED = 2'b10,
    PMT_SMI_BLOCK  = 2'b11
  } pmt_smi_t;

  typedef struct packed {
    logic        acc_valid;
    logic        acc_is_io;
    logic [19:0] acc_addr;
    logic        dma_req;
    logic        pci_req;
    logic        disk_acc;
    logic [1:0]  trap_hit;
  } pmt_evt_t;

  typedef struct packed {
    logic [2:0][15:0] cond;
    logic [2:0][15:0] irqm;
    logic [2:0]       ctrl;
    logic [1:0][31:0] per;
    logic [2:0][31:0] cnt;
    logic [15:0]      irq_prev;
    logic [3:0]       st;
    logic [3:0]       ien;
    pmt_smi_t         smi;
    logic             smi_pend;
    logic             smi_o;
    logic [7:0]       pulse;
    logic [31:0]      blk;
    logic             ack;
    logic [31:0]      dat;
  } pmt_state_t;

  // activity vector in reload-condition bit layout
  function automatic logic [9:0] pmt_events(input pmt_evt_t e, input logic [15:0] rise,
                                            input logic [15:0] irqm);
    logic [9:0] v;
    logic [9:0] p;
    logic       io;
    v = '0;
    p = e.acc_addr[9:0];
    io = e.acc_valid & e.acc_is_io & (e.acc_addr[15:10] == 6'h00);
    v[PMT_B_VIDEO] = (e.acc_valid & ~e.acc_is_io & (e.acc_addr[19:17] == 3'h5))
                   | (io & ((p[9:3] == 7'h76) | (p[9:4] == 6'h3C) | (p[9:4] == 6'h3D)));
    v[PMT_B_IRQ]   = |(rise & irqm);
    v[PMT_B_DMA]   = e.dma_req;
    v[PMT_B_KBD]   = rise[1] | rise[3] | rise[4] | rise[12];
    v[PMT_B_DISK]  = e.disk_acc;
    v[PMT_B_PAR]   = io & ((p[9:3] == 7'h4F) | (p[9:3] == 7'h6F) | (p[9:2] == 8'hEF));
    v[PMT_B_SER]   = io & ((p[9:3] == 7'h5F) | (p[9:3] == 7'h7F)
                         | (p[9:3] == 7'h5D) | (p[9:3] == 7'h7D));
    v[PMT_B_TRAP1] = e.trap_hit[1];
    v[PMT_B_TRAP0] = e.trap_hit[0];
    v[PMT_B_PCI]   = e.pci_req;
    return v;
  endfunction
endpackage
`default_nettype wire

// [rtl/pmt_idle_timers.sv]
// Implementation choice: the Wishbone slave port.
`default_nettype none
module pmt_idle_timers
  import pmt_pkg::*;
#(
  parameter logic [31:0] SLOW_CYC0 = 32'(PMT_SLOW_CYC0),
  parameter logic [31:0] SLOW_CYC1 = 32'(PMT_SLOW_CYC1),
  parameter logic [31:0] SLOW_CYC2 = 32'(PMT_SLOW_CYC2),
  parameter logic [31:0] SLOW_CYC3 = 32'(PMT_SLOW_CYC3)
)(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [9:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // system activity
  input  wire pmt_evt_t    evt_in,
  input  wire logic [15:0] irq_in,
  // processor side
  output logic             management_interrupt_out,
  output logic             irq_out
);
  // ****************
  // checks and helpers
  // ****************
  if ((SLOW_CYC0 == 32'h0) || (SLOW_CYC1 == 32'h0) || (SLOW_CYC2 == 32'h0)
      || (SLOW_CYC3 == 32'h0))
  begin : g_chk
    $error("slow timer periods must be nonzero");
  end

  function automatic logic [15:0] wr16(input logic [15:0] o, input logic [31:0] w,
                                       input logic [3:0] s);
    return {s[1] ? w[15:8] : o[15:8], s[0] ? w[7:0] : o[7:0]};
  endfunction

  function automatic logic [31:0] wr32(input logic [31:0] o, input logic [31:0] w,
                                       input logic [3:0] s);
    return {wr16(o[31:16], {16'h0, w[31:16]}, {2'b00, s[3:2]}), wr16(o[15:0], w, s)};
  endfunction

  // slow timer base select
  function automatic logic [31:0] slow_per(input logic [1:0] b);
    case (b)
      2'b00:   return SLOW_CYC0;
      2'b01:   return SLOW_CYC1;
      2'b10:   return SLOW_CYC2;
      default: return SLOW_CYC3;
    endcase
  endfunction

  pmt_state_t       q;
  pmt_state_t       d;
  logic [15:0]      rise;
  logic [2:0][9:0]  ev;
  logic [2:0]       reload;
  logic [2:0]       expire;
  logic [2:0][31:0] per_v;
  logic             req;
  logic             wr;
  logic [7:0]       idx;
  logic             soft_smi;
  logic             soft_blk;
  logic [3:0]       st_set;
  logic [3:0]       st_clr;
  logic [2:0]       newly_on;

  // ****************
  // next state
  // ****************
  always_comb
  begin
    d = q;
    rise = irq_in & ~q.irq_prev;
    d.irq_prev = irq_in;
    req = wb_cyc_in & wb_stb_in;
    wr = req & q.ack & wb_we_in;
    idx = wb_adr_in[9:2];
    soft_smi = 1'b0;
    soft_blk = 1'b0;
    st_clr = 4'h0;
    newly_on = 3'h0;
    per_v = {slow_per(q.cond[2][15:14]), q.per[1], q.per[0]};
    for (int i = 0; i < 3; i++)
    begin
      ev[i] = pmt_events(evt_in, rise, q.irqm[i]);
      reload[i] = |(ev[i] & q.cond[i][9:0]);
      expire[i] = q.ctrl[i] & ~reload[i] & (q.cnt[i] == 32'h1);
      if (!q.ctrl[i])
        d.cnt[i] = 32'h0;
      else if (reload[i])
        d.cnt[i] = per_v[i];
      else if (q.cnt[i] != 32'h0)
        d.cnt[i] = q.cnt[i] - 32'h1;
    end
    // ack one cycle after request, write at the ack edge
    d.ack = req & ~q.ack;
    if (req & ~q.ack)
    begin
      case (idx)
        PMT_IDX_FAST_COND: d.dat = {16'h0, q.cond[0]};
        PMT_IDX_GEN_COND:  d.dat = {16'h0, q.cond[1]};
        PMT_IDX_SLOW_COND: d.dat = {16'h0, q.cond[2]};
        PMT_IDX_FAST_IRQM: d.dat = {16'h0, q.irqm[0]};
        PMT_IDX_GEN_IRQM:  d.dat = {16'h0, q.irqm[1]};
        PMT_IDX_SLOW_IRQM: d.dat = {16'h0, q.irqm[2]};
        PMT_IDX_CTRL:      d.dat = {29'h0, q.ctrl};
        PMT_IDX_FAST_PER:  d.dat = q.per[0];
        PMT_IDX_GEN_PER:   d.dat = q.per[1];
        PMT_IDX_IST:       d.dat = {28'h0, q.st};
        PMT_IDX_IEN:       d.dat = {28'h0, q.ien};
        PMT_IDX_SMIST:     d.dat = {29'h0, q.smi_pend, q.smi};
        default:           d.dat = 32'h0;
      endcase
    end
    if (wr)
    begin
      case (idx)
        PMT_IDX_FAST_COND: d.cond[0] = wr16(q.cond[0], wb_dat_in, wb_sel_in) & PMT_COND_MASK;
        PMT_IDX_GEN_COND:  d.cond[1] = wr16(q.cond[1], wb_dat_in, wb_sel_in) & PMT_COND_MASK;
        PMT_IDX_SLOW_COND: d.cond[2] = wr16(q.cond[2], wb_dat_in, wb_sel_in) & PMT_SLOW_MASK;
        PMT_IDX_FAST_IRQM: d.irqm[0] = wr16(q.irqm[0], wb_dat_in, wb_sel_in);
        PMT_IDX_GEN_IRQM:  d.irqm[1] = wr16(q.irqm[1], wb_dat_in, wb_sel_in);
        PMT_IDX_SLOW_IRQM: d.irqm[2] = wr16(q.irqm[2], wb_dat_in, wb_sel_in);
        PMT_IDX_SOFT:
        begin
          soft_smi = wb_sel_in[0] & wb_dat_in[PMT_SOFT_SMI];
          soft_blk = wb_sel_in[0] & wb_dat_in[PMT_SOFT_BLK];
        end
        PMT_IDX_CTRL:
        begin
          if (wb_sel_in[0])
          begin
            newly_on = wb_dat_in[2:0] & ~q.ctrl;
            d.ctrl = wb_dat_in[2:0];
          end
        end
        PMT_IDX_FAST_PER:  d.per[0] = wr32(q.per[0], wb_dat_in, wb_sel_in);
        PMT_IDX_GEN_PER:   d.per[1] = wr32(q.per[1], wb_dat_in, wb_sel_in);
        PMT_IDX_ICLR:      st_clr = wb_sel_in[0] ? wb_dat_in[3:0] : 4'h0;
        PMT_IDX_IEN:       d.ien = wb_sel_in[0] ? wb_dat_in[3:0] : q.ien;
        default:           d.ien = q.ien;
      endcase
    end
    for (int i = 0; i < 3; i++)
    begin
      if (newly_on[i])
        d.cnt[i] = per_v[i];
    end
    st_set = {soft_smi, expire};
    d.st = (q.st & ~st_clr) | st_set;
    case (q.smi)
      PMT_SMI_IDLE:
      begin
        if (q.smi_pend)
        begin
          d.smi = PMT_SMI_DRIVE;
          d.pulse = PMT_PULSE_CYC;
          d.smi_pend = 1'b0;
        end
      end
      PMT_SMI_DRIVE:
      begin
        d.pulse = q.pulse - 8'h1;
        if (q.pulse == 8'h1)
          d.smi = PMT_SMI_MASKED;
      end
      PMT_SMI_MASKED:
      begin
        if (soft_blk)
        begin
          d.smi = PMT_SMI_BLOCK;
          d.blk = PMT_BLK_CYC;
        end
      end
      PMT_SMI_BLOCK:
      begin
        d.blk = q.blk - 32'h1;
        if (q.blk == 32'h1)
          d.smi = PMT_SMI_IDLE;
      end
      default: d.smi = PMT_SMI_IDLE;
    endcase
    // a new request stays pending behind the one being served
    if (|(st_set & q.ien) | soft_smi)
      d.smi_pend = 1'b1;
    d.smi_o = (d.smi == PMT_SMI_DRIVE);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      q <= '0;
    else
      q <= d;
  end

  assign wb_ack_out = q.ack;
  assign wb_dat_out = q.dat;
  assign management_interrupt_out = q.smi_o;
  assign irq_out = |(q.st & q.ien);

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  AST_SLOW_BASE: assert property (
    q.ctrl[2] && reload[2] && !wr |=> q.cnt[2] == slow_per($past(q.cond[2][15:14])))
    else $error("slow timer loaded wrong base");
  AST_VIDEO: assert property (
    evt_in.acc_valid && !evt_in.acc_is_io && evt_in.acc_addr[19:17] == 3'h5
    && q.cond[0][9] |-> reload[0])
    else $error("video access did not reload");
  AST_IRQ_MASK: assert property (
    q.cond[1] == 16'h0100 && (rise & q.irqm[1]) == 16'h0 |-> !reload[1])
    else $error("unmasked irq reloaded");
  AST_IRQ_HIT: assert property (
    q.cond[2][8] && |(rise & q.irqm[2]) |-> reload[2])
    else $error("masked irq missed");
  AST_KBD: assert property (
    q.cond[0][6] && rise[12] |-> reload[0])
    else $error("keyboard irq missed");
  AST_DISK: assert property (
    q.cond[1][5] && evt_in.disk_acc |-> reload[1])
    else $error("disk access missed");
  AST_PAR_SER: assert property (
    evt_in.acc_valid && evt_in.acc_is_io && evt_in.acc_addr[15:0] == 16'h037A
    |-> ev[0][4] && !ev[0][3])
    else $error("parallel decode wrong");
  AST_SER: assert property (
    evt_in.acc_valid && evt_in.acc_is_io && evt_in.acc_addr[15:0] == 16'h03EF |-> ev[2][3])
    else $error("serial decode wrong");
  AST_TRAP: assert property (
    q.cond[0][2:1] == 2'b10 && evt_in.trap_hit == 2'b01 && q.cond[0][9:3] == 7'h0
    && !q.cond[0][0] |-> !reload[0])
    else $error("disabled trap reloaded");
  AST_NO_NEST: assert property (
    $rose(q.smi_o) |-> $past(q.smi) == PMT_SMI_IDLE)
    else $error("nested management interrupt");
  AST_PULSE: assert property (
    $rose(q.smi_o) |-> q.smi_o [*4] ##1 !q.smi_o)
    else $error("interrupt pulse width wrong");
  AST_BLK: assert property (
    q.smi == PMT_SMI_MASKED && soft_blk |=> q.smi == PMT_SMI_BLOCK && q.blk == PMT_BLK_CYC)
    else $error("blocking timer not started");
  AST_SOFT: assert property (
    soft_smi && q.smi == PMT_SMI_IDLE |=> ##1 q.smi_o)
    else $error("soft trigger not asserted");
  AST_EXPIRE: assert property (
    expire[1] |=> q.st[1])
    else $error("expiry not recorded");
  AST_DMA: assert property (
    q.cond[2][7] && evt_in.dma_req |-> reload[2])
    else $error("dma missed");
  AST_RESTART: assert property (
    q.ctrl[0] && reload[0] && !wr |=> q.cnt[0] == $past(q.per[0]))
    else $error("reload not full period");

  // ****************
  // more reload and interrupt checks
  // ****************
  AST_COND_RES: assert property (
    q.cond[0][15:10] == 6'h00 && q.cond[1][15:10] == 6'h00)
    else $error("reserved condition bits set");
  AST_SLOW_RES: assert property (
    q.cond[2][13:10] == 4'h0)
    else $error("reserved slow condition bits set");
  AST_IRQ_EDGE: assert property (
    q.cond[0][8] && |(rise & q.irqm[0]) |-> reload[0])
    else $error("enabled irq edge missed");
  AST_KBD_ALL: assert property (
    q.cond[1][6] && |(rise & 16'h101A) |-> reload[1])
    else $error("keyboard or mouse irq missed");
  AST_VIDEO_IO: assert property (
    evt_in.acc_valid && evt_in.acc_is_io && evt_in.acc_addr[15:3] == 13'h0076 |-> ev[1][9])
    else $error("video port decode wrong");
  AST_PAR_LOW: assert property (
    evt_in.acc_valid && evt_in.acc_is_io && evt_in.acc_addr[15:3] == 13'h004F |-> ev[1][4])
    else $error("low parallel decode wrong");
  AST_PAR_BC: assert property (
    evt_in.acc_valid && evt_in.acc_is_io && evt_in.acc_addr[15:2] == 14'h00EF |-> ev[1][4])
    else $error("third parallel decode wrong");
  AST_SER_LOW: assert property (
    evt_in.acc_valid && evt_in.acc_is_io && evt_in.acc_addr[15:3] == 13'h005D |-> ev[1][3])
    else $error("low serial decode wrong");
  AST_SER_HIGH: assert property (
    evt_in.acc_valid && evt_in.acc_is_io && evt_in.acc_addr[15:3] == 13'h007F |-> ev[1][3])
    else $error("high serial decode wrong");
  AST_TRAP1: assert property (
    q.cond[1][2] && evt_in.trap_hit[1] |-> reload[1])
    else $error("trap hit missed");
  AST_PCI: assert property (
    q.cond[0][0] && evt_in.pci_req |-> reload[0])
    else $error("pci master request missed");
  AST_DMA_GEN: assert property (
    q.cond[1][7] && evt_in.dma_req |-> reload[1])
    else $error("dma missed on generic timer");
  AST_OFF_ZERO: assert property (
    !q.ctrl[1] && !newly_on[1] |=> q.cnt[1] == 32'h0)
    else $error("disabled timer counting");
  AST_GEN_RESTART: assert property (
    q.ctrl[1] && reload[1] && !wr |=> q.cnt[1] == $past(q.per[1]))
    else $error("generic reload not full period");
  AST_STICKY: assert property (
    q.st[0] && !st_clr[0] |=> q.st[0])
    else $error("status bit lost");
  AST_CLEAR: assert property (
    q.st[2] && st_clr[2] && !st_set[2] |=> !q.st[2])
    else $error("status bit not cleared");
  AST_SOFT_ST: assert property (
    soft_smi |=> q.st[PMT_ST_SOFT])
    else $error("soft request not recorded");
  AST_MASK_SET: assert property (
    $rose(q.smi_o) |-> ##4 q.smi == PMT_SMI_MASKED)
    else $error("mask not set after assertion");
  AST_MASKED_HOLD: assert property (
    q.smi == PMT_SMI_MASKED |=> q.smi != PMT_SMI_DRIVE)
    else $error("interrupt driven while masked");
  AST_PEND_KEEP: assert property (
    q.smi_pend && q.smi != PMT_SMI_IDLE |=> q.smi_pend)
    else $error("pending request lost");
  AST_BLK_IGNORED: assert property (
    q.smi == PMT_SMI_IDLE && soft_blk && !q.smi_pend |=> q.smi == PMT_SMI_IDLE)
    else $error("blocking start outside mask");
  AST_BLK_LEN: assert property (
    q.smi == PMT_SMI_BLOCK && q.blk != 32'h1 |=> q.smi == PMT_SMI_BLOCK)
    else $error("blocking time cut short");

  // ****************
  // cover points
  // ****************
  COV_SOFT: cover property (soft_smi ##[1:10] q.smi_o);
  COV_SLOW: cover property (expire[2]);
  COV_REL: cover property (q.smi == PMT_SMI_BLOCK ##1 q.smi == PMT_SMI_IDLE);
  COV_MASKED_REQ: cover property (q.smi == PMT_SMI_MASKED && q.smi_pend);
  COV_FAST_RELOAD: cover property (q.ctrl[0] && reload[0]);
endmodule
`default_nettype wire

// [bench/pmt_smi_host.sv]
`default_nettype none
module pmt_smi_host (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // management interrupt from the block
  input  wire logic       smi_in,
  // one entry per finished pulse
  output logic            done_out,
  output logic [7:0]      width_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q     <= 8'h00;
      done_out  <= 1'b0;
      width_out <= 8'h00;
    end
    else
    begin
      done_out <= 1'b0;
      if (smi_in)
        cnt_q <= cnt_q + 8'h01;
      else if (cnt_q != 8'h00)
      begin
        done_out  <= 1'b1;
        width_out <= cnt_q;
        cnt_q     <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/test_pmt_idle_timers.sv]
`default_nettype none
module test_pmt_idle_timers
  import pmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, smi, irq_o, smi_done;
  logic [9:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [3:0]  sel_v = 4'hF;
  logic [31:0] wb_dat_w, wb_dat_r, me, wexp, cv;
  logic [15:0] irq;
  logic [7:0]  smi_w;
  pmt_evt_t    evt;
  int          errors, checks;
  int          seed = 32'h83d9;
  logic [31:0] rq[$];
  logic [31:0] smi_q[$];
  int          bitof[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 9, 3, 4};
  logic [7:0]  rmap[8] = '{PMT_IDX_FAST_COND, PMT_IDX_GEN_COND, PMT_IDX_SLOW_COND,
                           PMT_IDX_FAST_IRQM, PMT_IDX_GEN_IRQM, PMT_IDX_SLOW_IRQM,
                           PMT_IDX_SOFT, 8'h40};
  logic [15:0] msk[6] = '{PMT_COND_MASK, PMT_COND_MASK, PMT_SLOW_MASK,
                          16'hFFFF, 16'hFFFF, 16'hFFFF};
  pmt_idle_timers #(
    .SLOW_CYC0 (32'h14),
    .SLOW_CYC1 (32'h28),
    .SLOW_CYC2 (32'h3C),
    .SLOW_CYC3 (32'h50)
  ) pmt_idle_timers_inst (
    .sys_clk_in               (clk),
    .rst_in                   (rst),
    .wb_cyc_in                (wb_cyc),
    .wb_stb_in                (wb_stb),
    .wb_we_in                 (wb_we),
    .wb_adr_in                (wb_adr),
    .wb_sel_in                (wb_sel),
    .wb_dat_in                (wb_dat_w),
    .wb_dat_out               (wb_dat_r),
    .wb_ack_out               (wb_ack),
    .evt_in                   (evt),
    .irq_in                   (irq),
    .management_interrupt_out (smi),
    .irq_out                  (irq_o)
  );
  pmt_smi_host pmt_smi_host_inst (
    .clk_in    (clk),
    .rst_in    (rst),
    .smi_in    (smi),
    .done_out  (smi_done),
    .width_out (smi_w)
  );
  // ****************
  // clock, checks, bus
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= {i, 2'b00};
    wb_dat_w <= d;
    wb_sel   <= sel_v;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    wb(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, i, 32'h0);
  endtask
  task automatic ev(input int k);
    pmt_evt_t    v;
    logic [15:0] r;
    v = '0;
    r = 16'h0000;
    case (k)
      9: {v.acc_valid, v.acc_addr} = {1'b1, 20'hA0000};
      8: r = 16'h0020;
      7: v.dma_req = 1'b1;
      6: r = 16'h1000;
      5: v.disk_acc = 1'b1;
      4: {v.acc_valid, v.acc_is_io, v.acc_addr} = {2'b11, 20'h0037A};
      3: {v.acc_valid, v.acc_is_io, v.acc_addr} = {2'b11, 20'h003EF};
      2: v.trap_hit = 2'b10;
      1: v.trap_hit = 2'b01;
      0: v.pci_req = 1'b1;
      10: {v.acc_valid, v.acc_is_io, v.acc_addr} = {2'b11, 20'h003C4};
      11: {v.acc_valid, v.acc_is_io, v.acc_addr} = {2'b11, 20'h002F8};
      default: {v.acc_valid, v.acc_is_io, v.acc_addr} = {2'b11, 20'h003BC};
    endcase
    @(posedge clk);
    evt <= v;
    irq <= r;
    @(posedge clk);
    evt <= '0;
    irq <= 16'h0000;
  endtask
  // ****************
  // result watcher
  // ****************
  always @(posedge clk)
  begin
    if (wb_ack === 1'b1 && wb_we === 1'b0)
    begin
      wexp = (rq.size() > 0) ? rq.pop_front() : 32'hDEAD_BEEF;
      chk("wb_dat", wexp, wb_dat_r);
    end
    if (smi_done === 1'b1)
    begin
      wexp = (smi_q.size() > 0) ? smi_q.pop_front() : 32'h0;
      chk("smi_width", wexp, {24'h0, smi_w});
    end
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    results();
  end
  // ****************
  // scenarios
  // ****************
  initial
  begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w, evt, irq} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rmap[i]) rd(rmap[i], 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      me = $random(seed);
      sel_v = 4'($random(seed));
      wr(rmap[i], me);
      rd(rmap[i], me & {16'h0, msk[i]} & {16'h0, {8{sel_v[1]}}, {8{sel_v[0]}}});
    end
    sel_v = 4'hF;
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    wr(PMT_IDX_FAST_IRQM, 32'h0020);
    wr(PMT_IDX_GEN_IRQM, 32'h0000);
    wr(PMT_IDX_SLOW_IRQM, 32'h0020);
    wr(PMT_IDX_FAST_PER, 32'h1E);
    for (int n = 0; n < 2; n++)
      for (int k = 0; k < 13; k++)
      begin
        cv = (n == 1) ? 32'h0 : (32'h1 << bitof[k]);
        wr(PMT_IDX_FAST_COND, cv);
        wr(PMT_IDX_GEN_COND, cv);
        wr(PMT_IDX_SLOW_COND, cv);
        wr(PMT_IDX_CTRL, 32'h1);
        repeat (4)
        begin
          repeat (18) @(posedge clk);
          ev(k);
        end
        rd(PMT_IDX_IST, 32'(n));
        repeat (40) @(posedge clk);
        rd(PMT_IDX_IST, 32'h1);
        wr(PMT_IDX_CTRL, 32'h0);
        wr(PMT_IDX_ICLR, 32'h1);
      end
    for (int b = 0; b < 4; b++)
    begin
      wr(PMT_IDX_SLOW_COND, (32'(b) << PMT_BASE_LSB) | (32'h1 << PMT_B_DMA));
      wr(PMT_IDX_CTRL, 32'h4);
      ev(7);
      repeat (20 * (b + 1) - 8) @(posedge clk);
      rd(PMT_IDX_IST, 32'h0);
      repeat (10) @(posedge clk);
      rd(PMT_IDX_IST, 32'h4);
      wr(PMT_IDX_CTRL, 32'h0);
      wr(PMT_IDX_ICLR, 32'h4);
    end
    smi_q.push_back(32'h4);
    wr(PMT_IDX_SOFT, 32'h1);
    repeat (10) @(posedge clk);
    rd(PMT_IDX_IST, 32'h8);
    rd(PMT_IDX_SMIST, 32'h2);
    wr(PMT_IDX_ICLR, 32'h8);
    wr(PMT_IDX_IEN, 32'h1);
    wr(PMT_IDX_GEN_PER, 32'h1E);
    wr(PMT_IDX_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    chk("irq_out", 32'h1, {31'h0, irq_o});
    wr(PMT_IDX_ICLR, 32'h1);
    @(posedge clk);
    chk("irq_out", 32'h0, {31'h0, irq_o});
    wr(PMT_IDX_IEN, 32'h0);
    wr(PMT_IDX_CTRL, 32'h0);
    wr(PMT_IDX_SOFT, 32'h1);
    rd(PMT_IDX_SMIST, 32'h6);
    wr(PMT_IDX_ICLR, 32'h8);
    smi_q.push_back(32'h4);
    wr(PMT_IDX_SOFT, 32'h2);
    repeat (260) @(posedge clk);
    rd(PMT_IDX_SMIST, 32'h2);
    wr(PMT_IDX_SOFT, 32'h0);
    wr(PMT_IDX_SOFT, 32'h2);
    repeat (210) @(posedge clk);
    rd(PMT_IDX_SMIST, 32'h0);
    repeat (20) @(posedge clk);
    chk("smi_left", 32'h0, 32'(smi_q.size()));
    results();
  end
endmodule
`default_nettype wire
